// *** hw/hbi_pkg.sv ***
// Constants shared by the host bus port of the two-axis pulse controller.
// Assumes a single 20 MHz reference clock and a synchronous active-low reset.
package hbi_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // Clock rate in kHz and the command processing time in reference periods.
  localparam int unsigned CLK_KHZ        = 20000;
  localparam int unsigned CMD_PERIODS    = 4;
  // Cycles the port stays busy after taking a command.
  localparam logic [2:0]  CMD_CYCLES     = 3'(CMD_PERIODS);
  // Least reset hold in reference periods, for the bench.
  localparam int unsigned RST_MIN_CYCLES = 10;

  // ==========================================================================
  // Address map on the four address lines
  // ==========================================================================
  localparam logic [3:0] ADR_STATUS      = 4'h0;
  localparam logic [3:0] ADR_ERR_CAUSE   = 4'h1;
  localparam logic [3:0] ADR_EVT_CAUSE   = 4'h2;
  localparam logic [3:0] ADR_IRQ_MASK    = 4'h3;

  // ==========================================================================
  // Status word fields and reset values
  // ==========================================================================
  localparam int unsigned STAT_IRQ_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT  = 1;
  localparam int unsigned STAT_MODE_LSB  = 2;
  localparam int unsigned STAT_ERR_BIT   = 4;
  localparam int unsigned STAT_EVT_BIT   = 5;
  localparam logic [15:0] MASK_RST       = 16'h0001;
  localparam logic [15:0] CAUSE_RST      = 16'h0000;

  // ==========================================================================
  // Host bus protocol variants selected by the two mode pins
  // ==========================================================================
  typedef enum logic [1:0] {
    HBI_MODE_A = 2'h0,
    HBI_MODE_B = 2'h1,
    HBI_MODE_C = 2'h2,
    HBI_MODE_D = 2'h3
  } hbi_mode_e;

endpackage

// *** hw/hbi_sync2.sv ***
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk_in; reset is synchronous active low.
`timescale 1ns/1ns
`default_nettype none

module hbi_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Raw pin levels and their synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Two stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second.

  // Both stages register every edge; the second is the only consumer of the first.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

  // The reset value port is kept constant-free of use; idle levels are all ones.
  logic unused_ok;
  assign unused_ok = ^reset_val_in;

endmodule

`default_nettype wire

// *** hw/hbi_host_port.sv ***
// Host-facing control port of a two-axis pulse controller: strobes, address,
// mode select, command wait/busy and the interrupt request pin.
// Assumes an external CPU on an asynchronous parallel bus and one reference clock.
`timescale 1ns/1ns
`default_nettype none

module hbi_host_port (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Host bus pins; chip select and both strobes are active low.
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [3:0]  host_address_lines_in,
  input  wire logic        host_mode_select_lo_in,
  input  wire logic        host_mode_select_hi_in,
  // Data bus as three signals; enable low while driving.
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe_n_out,
  // Handshake outputs.
  output logic             wait_request_n_out,
  output logic             interface_busy_n_out,
  // Interrupt request pin and event sources from the axis logic.
  output logic             irq_n_out,
  input  wire logic [15:0] err_event_in,
  input  wire logic [15:0] evt_event_in,
  // Latched protocol variant for the rest of the chip.
  output hbi_pkg::hbi_mode_e host_mode_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [23:0] pins_s;  // Synchronised pin bundle.

  // All bus pins except data bit 15 pass two flip-flops before any logic reads them.
  hbi_sync2 #(.WIDTH(24)) u_sync (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .async_in     ({cs_n_in, rd_n_in, wr_n_in, host_address_lines_in,
                    host_mode_select_hi_in, host_mode_select_lo_in,
                    data_in[14:0]}),
    .reset_val_in ('1),
    .sync_out     (pins_s)
  );

  logic        cs_n_s;  // Chip select, active low.
  logic        rd_n_s;  // Read strobe, active low.
  logic        wr_n_s;  // Write strobe, active low.
  logic [3:0]  adr_s;   // Address lines.
  logic [1:0]  mode_s;  // Mode select pins.
  logic [14:0] dat_s;   // Write data low bits; bit 15 of the mask is unused.

  assign cs_n_s = pins_s[23];
  assign rd_n_s = pins_s[22];
  assign wr_n_s = pins_s[21];
  assign adr_s  = pins_s[20:17];
  assign mode_s = pins_s[16:15];
  assign dat_s  = pins_s[14:0];

  // ==========================================================================
  // Strobe qualification and command sequencer
  // ==========================================================================
  typedef enum logic [1:0] {
    HBI_ST_IDLE = 2'b01,
    HBI_ST_BUSY = 2'b10
  } hbi_state_e;

  hbi_state_e state_r, state_nxt;    // Sequencer state.
  logic [2:0] cnt_r, cnt_nxt;        // Cycles left in the command.
  logic       rd_q_r, rd_q_nxt;      // Previous qualified read.
  logic       wr_q_r, wr_q_nxt;      // Previous qualified write.
  logic       wr_cmd_r, wr_cmd_nxt;  // Current command is a write.
  logic [3:0] cadr_r, cadr_nxt;      // Address held for the command.
  logic [14:0] cdat_r, cdat_nxt;     // Write data held for the command.
  hbi_pkg::hbi_mode_e mode_r, mode_nxt;  // Protocol variant.
  logic       rd_act, wr_act;        // Qualified strobe levels.
  logic       rd_go, wr_go;          // Strobe leading edges.
  logic       done;                  // Last cycle of a command.

  // A strobe counts only while chip select is low.
  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;
  assign rd_go  = rd_act && !rd_q_r;
  assign wr_go  = wr_act && !wr_q_r;

  // Next-state logic: a command occupies a fixed count of reference clocks.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    rd_q_nxt   = rd_act;
    wr_q_nxt   = wr_act;
    wr_cmd_nxt = wr_cmd_r;
    cadr_nxt   = cadr_r;
    cdat_nxt   = cdat_r;
    mode_nxt   = hbi_pkg::hbi_mode_e'(mode_s);
    done       = 1'b0;
    case (state_r)
      HBI_ST_IDLE: begin
        // Only a fresh strobe edge starts a command.
        if (rd_go || wr_go) begin
          state_nxt  = HBI_ST_BUSY;
          cnt_nxt    = hbi_pkg::CMD_CYCLES - 3'h1;
          wr_cmd_nxt = wr_go;
          cadr_nxt   = adr_s;
          cdat_nxt   = dat_s;
        end
      end
      HBI_ST_BUSY: begin
        // Count down; new strobes are ignored until done.
        if (cnt_r == 3'h0) begin
          state_nxt = HBI_ST_IDLE;
          done      = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: begin
        state_nxt = HBI_ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r  <= HBI_ST_IDLE;
      cnt_r    <= 3'h0;
      rd_q_r   <= 1'b0;
      wr_q_r   <= 1'b0;
      wr_cmd_r <= 1'b0;
      cadr_r   <= 4'h0;
      cdat_r   <= 15'h0000;
      mode_r   <= hbi_pkg::HBI_MODE_A;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      rd_q_r   <= rd_q_nxt;
      wr_q_r   <= wr_q_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      cadr_r   <= cadr_nxt;
      cdat_r   <= cdat_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // Wait request is low for the whole command; busy only for writes.
  assign wait_request_n_out   = (state_r != HBI_ST_BUSY);
  assign interface_busy_n_out = !((state_r == HBI_ST_BUSY) && wr_cmd_r);
  assign host_mode_out        = mode_r;

  // ==========================================================================
  // Interrupt causes, mask and pin
  // ==========================================================================
  logic [15:0] err_r, err_nxt;    // Pending error causes.
  logic [15:0] evt_r, evt_nxt;    // Pending event causes.
  logic        mask_r, mask_nxt;  // Interrupt mask, one blocks the pin.
  logic        irq_r, irq_nxt;    // Interrupt pin, active high internally.
  logic [15:0] rdat_r, rdat_nxt;  // Read data register.
  logic        oe_r, oe_nxt;      // Data drive, active high internally.
  logic        rd_err, rd_evt;    // Finished cause readouts.

  assign rd_err = done && !wr_cmd_r && (cadr_r == hbi_pkg::ADR_ERR_CAUSE);
  assign rd_evt = done && !wr_cmd_r && (cadr_r == hbi_pkg::ADR_EVT_CAUSE);

  // Causes are sticky; an event in the clearing cycle wins over the clear.
  always_comb begin
    err_nxt  = (rd_err ? 16'h0000 : err_r) | err_event_in;
    evt_nxt  = (rd_evt ? 16'h0000 : evt_r) | evt_event_in;
    mask_nxt = mask_r;
    rdat_nxt = rdat_r;
    oe_nxt   = (state_r == HBI_ST_BUSY) && !wr_cmd_r && rd_act;
    // A finished write to the mask address updates the mask.
    if (done && wr_cmd_r && (cadr_r == hbi_pkg::ADR_IRQ_MASK)) begin
      mask_nxt = cdat_r[0];
    end
    // Read data is captured when a read command starts.
    if ((state_r == HBI_ST_IDLE) && rd_go) begin
      if (adr_s == hbi_pkg::ADR_STATUS) begin
        rdat_nxt = 16'h0000;
        rdat_nxt[hbi_pkg::STAT_IRQ_BIT]  = irq_r;
        rdat_nxt[hbi_pkg::STAT_BUSY_BIT] = 1'b1;
        rdat_nxt[hbi_pkg::STAT_MODE_LSB +: 2] = mode_r;
        rdat_nxt[hbi_pkg::STAT_ERR_BIT]  = |err_r;
        rdat_nxt[hbi_pkg::STAT_EVT_BIT]  = |evt_r;
      end else if (adr_s == hbi_pkg::ADR_ERR_CAUSE) begin
        rdat_nxt = err_r;
      end else if (adr_s == hbi_pkg::ADR_EVT_CAUSE) begin
        rdat_nxt = evt_r;
      end else if (adr_s == hbi_pkg::ADR_IRQ_MASK) begin
        rdat_nxt = {15'h0000, mask_r};
      end else begin
        rdat_nxt = 16'h0000;
      end
    end
    // The pin follows pending causes; it drops once a readout leaves no cause pending.
    // Unmasking with causes still pending raises it again.
    irq_nxt = !mask_nxt && ((|err_nxt) || (|evt_nxt));
  end

  // Registers of the interrupt group.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      err_r  <= hbi_pkg::CAUSE_RST;
      evt_r  <= hbi_pkg::CAUSE_RST;
      mask_r <= hbi_pkg::MASK_RST[0];
      irq_r  <= 1'b0;
      rdat_r <= 16'h0000;
      oe_r   <= 1'b0;
    end else begin
      err_r  <= err_nxt;
      evt_r  <= evt_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
      rdat_r <= rdat_nxt;
      oe_r   <= oe_nxt;
    end
  end

  assign irq_n_out     = !irq_r;
  assign data_out      = rdat_r;
  assign data_oe_n_out = !oe_r;

  // Data bit 15 is never written into any register.
  logic unused_d15;
  assign unused_d15 = data_in[15];

endmodule

`default_nettype wire

// *** test/hbi_host_port_props.sv ***
// Checker for the host port: command handshake, strobe gating, mode and irq.
// Assumes it is bound onto hbi_host_port and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module hbi_host_port_props (
  // Clock, reset and host pins.
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               cs_n_in,
  input wire logic               rd_n_in,
  input wire logic               wr_n_in,
  input wire logic [3:0]         host_address_lines_in,
  input wire logic               host_mode_select_lo_in,
  input wire logic               host_mode_select_hi_in,
  // Outputs under watch.
  input wire logic               wait_request_n_out,
  input wire logic               interface_busy_n_out,
  input wire logic               data_oe_n_out,
  input wire logic               irq_n_out,
  input wire hbi_pkg::hbi_mode_e host_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles since the last cause readout or mask write strobe, saturating at 15.
  // Masking may also drop the pin, so a mask write restarts the count as well.
  logic [3:0] rd_age_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_age_r <= 4'hF;
    end else if (!cs_n_in && ((!rd_n_in && host_address_lines_in inside {4'h1, 4'h2}) ||
                 (!wr_n_in && host_address_lines_in == 4'h3))) begin
      rd_age_r <= 4'h0;
    end else if (rd_age_r != 4'hF) begin
      rd_age_r <= rd_age_r + 4'h1;
    end
  end
  wait_len_a: assert property ($fell(wait_request_n_out) |->
    (!wait_request_n_out)[*4] ##1 wait_request_n_out) else $error("wait not four cycles");
  busy_len_a: assert property ($fell(interface_busy_n_out) |->
    (!interface_busy_n_out)[*4] ##1 interface_busy_n_out) else $error("busy length wrong");
  busy_wr_a: assert property ($fell(interface_busy_n_out) |->
    !wr_n_in && !$past(wr_n_in) && !wait_request_n_out) else $error("busy without write");
  cs_gate_a: assert property (cs_n_in && $past(cs_n_in) && $past(cs_n_in, 2)
    && $past(cs_n_in, 3) |-> !$fell(wait_request_n_out)) else $error("strobe without select");
  mode_pins_a: assert property (($stable(host_mode_select_lo_in) &&
    $stable(host_mode_select_hi_in))[*4] |-> host_mode_out ==
    {host_mode_select_hi_in, host_mode_select_lo_in}) else $error("mode not followed");
  irq_hold_a: assert property ($rose(irq_n_out) |-> rd_age_r < 4'hC)
    else $error("irq dropped without readout");
  oe_busy_a: assert property ($fell(data_oe_n_out) |->
    !wait_request_n_out && !rd_n_in && !cs_n_in) else $error("data driven outside read");
  rst_idle_a: assert property ($rose(rst_n_in) |-> irq_n_out &&
    wait_request_n_out && interface_busy_n_out && data_oe_n_out) else $error("bad reset state");
endmodule

bind hbi_host_port hbi_host_port_props u_props (.clk_in, .rst_n_in, .cs_n_in, .rd_n_in,
  .wr_n_in, .host_address_lines_in, .host_mode_select_lo_in, .host_mode_select_hi_in,
  .wait_request_n_out, .interface_busy_n_out, .data_oe_n_out, .irq_n_out, .host_mode_out);

`default_nettype wire

// *** test/hbi_cpu_model.sv ***
// Host CPU model: one strobe cycle at a time on the asynchronous bus.
// Assumes a free-running clk_in; its pins change at falling edges only.
`timescale 1ns/1ns
`default_nettype none

module hbi_cpu_model (
  // Clock and answers from the port.
  input  wire logic        clk_in,
  input  wire logic        wait_n_in,
  input  wire logic        busy_n_in,
  input  wire logic [15:0] rdata_in,
  // Bus pins towards the port.
  output logic             cs_n_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic [3:0]       addr_out,
  output logic [15:0]      wdata_out
);
  // Idle bus at time zero.
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 4'h0;
    wdata_out = 16'h0000;
  end
  // One bus cycle; fl reports {busy seen, wait seen}.
  task automatic acc(input logic sel, input logic wr, input logic [3:0] a,
                     input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] fl);
    int n;
    fl = 2'b00;
    rd = 16'h0000;
    @(negedge clk_in);
    cs_n_out <= ~sel;
    addr_out <= a;
    wdata_out <= wd;
    wr_n_out <= ~wr;
    rd_n_out <= wr;
    // Hold the strobe until the port asks us to wait, then until it lets go.
    for (n = 0; n < 12 && wait_n_in !== 1'b0; n++) @(negedge clk_in);
    if (wait_n_in === 1'b0) begin
      fl = {~busy_n_in, 1'b1};
      // Hold the request until the wait is lifted, then take the read data.
      for (n = 0; n < 12 && wait_n_in !== 1'b1; n++) @(negedge clk_in);
      rd = rdata_in;
    end
    // Released lines do not keep their last value.
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    addr_out <= ~a;
    wdata_out <= ~wd;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

`default_nettype wire

// *** test/testbench.sv ***
// Testbench for the host port: bus cycles, mode pins and interrupt flow.
// Assumes hbi_cpu_model drives the bus and the checker is bound separately.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic               clk_in, rst_n_in, lo, hi, wt_n, bz_n, oe_n, irq_n, cs_n, rd_n, wr_n;
  logic [3:0]         adr;
  logic [15:0]        wd, rdat, err_ev, evt_ev, s;
  logic [1:0]         fl;
  hbi_pkg::hbi_mode_e mode;
  int                 n_errors = 0, check_count = 0, cyc = 0;

  hbi_host_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .host_address_lines_in(adr), .host_mode_select_lo_in(lo),
    .host_mode_select_hi_in(hi), .data_in(wd), .data_out(rdat), .data_oe_n_out(oe_n),
    .wait_request_n_out(wt_n), .interface_busy_n_out(bz_n), .irq_n_out(irq_n),
    .err_event_in(err_ev), .evt_event_in(evt_ev), .host_mode_out(mode));
  hbi_cpu_model cpu (.clk_in(clk_in), .wait_n_in(wt_n), .busy_n_in(bz_n), .rdata_in(rdat),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(adr), .wdata_out(wd));

  // Reference clock, 50 ns period.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Cuts a hang short.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rdr(input logic [3:0] a);
    cpu.acc(1'b1, 1'b0, a, 16'h0000, s, fl);
  endtask
  // One-cycle event pulses from the axis side.
  task automatic pulse(input logic [15:0] e, input logic [15:0] v);
    @(negedge clk_in);
    err_ev <= e;
    evt_ev <= v;
    @(negedge clk_in);
    err_ev <= 16'h0000;
    evt_ev <= 16'h0000;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic t_reset();
    chk({12'h000, irq_n, wt_n, bz_n, oe_n}, 16'h000F);
    rdr(hbi_pkg::ADR_STATUS);
    chk(s & 16'h0037, 16'h0002);
    rdr(hbi_pkg::ADR_ERR_CAUSE);
    chk(s, hbi_pkg::CAUSE_RST);
    $display("reset test done");
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_in);
      {hi, lo} <= 2'(m);
      repeat (5) @(negedge clk_in);
      chk({14'h0000, mode}, 16'(m));
      rdr(hbi_pkg::ADR_STATUS);
      chk({14'h0000, s[hbi_pkg::STAT_MODE_LSB +: 2]}, 16'(m));
    end
    $display("mode test done");
  endtask
  task automatic t_cmd();
    cpu.acc(1'b0, 1'b1, hbi_pkg::ADR_IRQ_MASK, 16'h0000, s, fl);
    chk({14'h0000, fl}, 16'h0000);
    rdr(hbi_pkg::ADR_IRQ_MASK);
    chk(s, 16'h0001);
    cpu.acc(1'b1, 1'b1, hbi_pkg::ADR_IRQ_MASK, 16'h0001, s, fl);
    chk({14'h0000, fl}, 16'h0003);
    rdr(hbi_pkg::ADR_STATUS);
    chk({14'h0000, fl}, 16'h0001);
    $display("command test done");
  endtask
  task automatic t_irq();
    pulse(16'h0008, 16'h0000);
    chk({15'h0000, irq_n}, 16'h0001);
    rdr(hbi_pkg::ADR_STATUS);
    chk({14'h0000, s[hbi_pkg::STAT_ERR_BIT], s[hbi_pkg::STAT_IRQ_BIT]}, 16'h0002);
    cpu.acc(1'b1, 1'b1, hbi_pkg::ADR_IRQ_MASK, 16'h0000, s, fl);
    chk({15'h0000, irq_n}, 16'h0000);
    pulse(16'h0000, 16'h0001);
    rdr(hbi_pkg::ADR_STATUS);
    chk({15'h0000, s[hbi_pkg::STAT_IRQ_BIT]}, 16'h0001);
    rdr(hbi_pkg::ADR_ERR_CAUSE);
    chk(s, 16'h0008);
    chk({15'h0000, irq_n}, 16'h0000);
    rdr(hbi_pkg::ADR_EVT_CAUSE);
    chk(s, 16'h0001);
    chk({15'h0000, irq_n}, 16'h0001);
    rdr(hbi_pkg::ADR_ERR_CAUSE);
    chk(s, 16'h0000);
    cpu.acc(1'b1, 1'b1, hbi_pkg::ADR_IRQ_MASK, 16'h0001, s, fl);
    rdr(hbi_pkg::ADR_IRQ_MASK);
    chk(s, 16'h0001);
    $display("interrupt test done");
  endtask
  // Main sequence: reset long enough, then each scenario in turn.
  initial begin
    rst_n_in = 1'b0;
    lo = 1'b0;
    hi = 1'b0;
    err_ev = 16'h0000;
    evt_ev = 16'h0000;
    repeat (hbi_pkg::RST_MIN_CYCLES) @(negedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    t_reset();
    t_mode();
    t_cmd();
    t_irq();
    print_verdict();
  end
endmodule

`default_nettype wire
